// ==== logic/io_cell_defines.vh ====
// offsets, field positions, reset values and timing counts for the i/o register cell
`ifndef IO_CELL_DEFINES_VH
`define IO_CELL_DEFINES_VH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_TXDATA 12'h008
`define OFS_RXDATA 12'h00C
`define OFS_PRESET 12'h010

// control register fields
`define CTRL_DDR_EN 0
`define CTRL_OUT_EN 1
`define CTRL_DIFF 2
`define CTRL_HOT_REQ 3
`define CTRL_PCI 4
`define CTRL_TOL5V 5
`define CTRL_BYPASS 6
`define CTRL_DLY_LO 7
`define CTRL_DLY_HI 9
`define CTRL_RESET 32'h0000_0040

// preset register fields: value held, write-one strobe
`define PRE_VALUE 0
`define PRE_STROBE 1

// status register fields
`define STAT_HOT_ON 0
`define STAT_LCLK 1
`define STAT_PAIRS_LO 8
`define STAT_PAIRS_HI 15

// rx data fields
`define RX_RISE 0
`define RX_FALL 1

// input delay: figures in picoseconds, one tap per pclk cycle in this clock domain
`define DLY_MIN_PS 625
`define DLY_MAX_PS 6575
`define DLY_STEP_PS 850
`define DLY_TAPS 8

// highest link rate the ddr path is rated for
`define DDR_MAX_MHZ 350

`endif

// ==== logic/sync_two_stage.v ====
// two flip-flop synchroniser for inputs from outside the pclk domain
`timescale 1ns/1ps
module sync_two_stage #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // levels
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ==== logic/io_ddr_register_cell.v ====
// registered part of one i/o cell: input, output and enable registers with ddr paths
// How it works
// - cell owns input, output, enable registers
// - register chain length follows single/differential mode
// - one shared clear/preset for all registers but the second input register
// - second input register has no clear/preset
// - ddr data changes on both link edges
// - three input registers, pair out per rise
// - ddr output drives new value each half period
// - ddr rated up to 350 mhz link
// - every tile captures ddr independently
// - 3-bit delay or bypass, equal steps
// - hot insertion per cell, not pci/5v
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "io_cell_defines.vh"
module io_ddr_register_cell (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // link side
   input wire link_clk,
   input wire pad_in,
   output reg pad_out,
   output wire pad_oe_n,
   output wire hot_insert_en
);

   // address decode, shared by the read and write paths
   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_TXDATA) ||
                  (a == `OFS_RXDATA) || (a == `OFS_PRESET);
      end
   endfunction

   reg [31:0] ctrl_q;
   reg preset_val_q;
   reg tx_rise_q;
   reg tx_fall_q;
   reg [7:0] pairs_q;

   wire setup = psel & ~penable;
   wire wr_acc = psel & penable & pwrite;
   wire clr_pulse = wr_acc & (paddr == `OFS_PRESET) & pwdata[`PRE_STROBE];
   // the shared clear/preset loads the value written with the strobe, not the old one
   wire clr_val = pwdata[`PRE_VALUE];

   assign pready = 1'b1;

   // software side registers: next values, then the flops
   reg [31:0] ctrl_d;
   reg preset_val_d;
   reg tx_rise_d;
   reg tx_fall_d;

   // writes land only at the access edge, so a setup cycle never disturbs state
   always @* begin
      ctrl_d = ctrl_q;
      preset_val_d = preset_val_q;
      tx_rise_d = tx_rise_q;
      tx_fall_d = tx_fall_q;
      if (wr_acc) begin
         case (paddr)
            `OFS_CTRL: begin
               // bits above the delay code are not implemented and read as zero
               ctrl_d = pwdata & 32'h0000_03FF;
            end
            `OFS_TXDATA: begin
               tx_rise_d = pwdata[`RX_RISE];
               tx_fall_d = pwdata[`RX_FALL];
            end
            `OFS_PRESET: begin
               preset_val_d = pwdata[`PRE_VALUE];
            end
            default: begin
               // status, rx data and unmapped words ignore writes
               ctrl_d = ctrl_q;
            end
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RESET;
         preset_val_q <= 1'b0;
         tx_rise_q <= 1'b0;
         tx_fall_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         preset_val_q <= preset_val_d;
         tx_rise_q <= tx_rise_d;
         tx_fall_q <= tx_fall_d;
      end
   end

   wire ddr_en = ctrl_q[`CTRL_DDR_EN];
   wire diff_mode = ctrl_q[`CTRL_DIFF];
   wire bypass = ctrl_q[`CTRL_BYPASS];
   wire [2:0] dly_code = ctrl_q[`CTRL_DLY_HI:`CTRL_DLY_LO];

   // pci and 5 v tolerant modes keep their clamp diodes, so hot insertion is blocked
   function hot_allowed;
      input [31:0] c;
      begin
         hot_allowed = c[`CTRL_HOT_REQ] & ~c[`CTRL_PCI] & ~c[`CTRL_TOL5V];
      end
   endfunction

   assign hot_insert_en = hot_allowed(ctrl_q);

   // link clock and pad are asynchronous to pclk
   wire [1:0] synced;
   sync_two_stage #(
      .WIDTH(2)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({pad_in, link_clk}),
      .sync_out(synced)
   );
   wire lclk_s = synced[0];
   wire din_s = synced[1];

   reg lclk_d_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lclk_d_q <= 1'b0;
      end else begin
         lclk_d_q <= lclk_s;
      end
   end
   wire lrise = lclk_s & ~lclk_d_q;
   wire lfall = ~lclk_s & lclk_d_q;

   // input delay line: one tap per pclk, code n selects n+1 taps, equal steps
   reg [`DLY_TAPS-1:0] tap_q;
   wire [`DLY_TAPS-1:0] tap_d = {tap_q[`DLY_TAPS-2:0], din_s};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tap_q <= {`DLY_TAPS{1'b0}};
      end else begin
         tap_q <= tap_d;
      end
   end

   // tap select: bypass takes the synced pin, code n the tap n+1 cycles back
   // long codes against a fast link slide the phases; the user picks the code
   function tap_pick;
      input [`DLY_TAPS-1:0] taps;
      input [2:0] code;
      input byp;
      input direct;
      begin
         if (byp) begin
            tap_pick = direct;
         end else begin
            tap_pick = taps[code];
         end
      end
   endfunction

   wire din_dly = tap_pick(tap_q, dly_code, bypass, din_s);

   // input registers: first on rise, second on fall, third retimes the second
   reg in_rise_q;
   reg in_fall_q;
   reg in_fall_rt_q;
   reg in_chain_q;
   reg rx_rise_q;
   reg rx_fall_q;

   // the second register carries only the fall phase and takes no clear/preset
   always @(posedge pclk) begin
      if (lfall && ddr_en) begin
         in_fall_q <= din_dly;
      end
   end

   // next values of the input chain; a clear/preset wins over a link edge that cycle
   reg in_rise_d;
   reg in_fall_rt_d;
   reg in_chain_d;
   reg rx_rise_d;
   reg rx_fall_d;
   reg [7:0] pairs_d;

   always @* begin
      in_rise_d = in_rise_q;
      in_fall_rt_d = in_fall_rt_q;
      in_chain_d = in_chain_q;
      rx_rise_d = rx_rise_q;
      rx_fall_d = rx_fall_q;
      pairs_d = pairs_q;
      if (clr_pulse) begin
         in_rise_d = clr_val;
         in_fall_rt_d = clr_val;
         in_chain_d = clr_val;
         rx_rise_d = clr_val;
         rx_fall_d = clr_val;
      end else if (lrise) begin
         in_rise_d = din_dly;
         in_chain_d = in_rise_q;
         // differential transfer chains two extra input registers
         rx_rise_d = diff_mode ? in_chain_q : din_dly;
         if (ddr_en) begin
            in_fall_rt_d = in_fall_q;
            rx_fall_d = in_fall_q;
            // the count wraps; software reads differences, not totals
            pairs_d = pairs_q + 8'h01;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_rise_q <= 1'b0;
         in_fall_rt_q <= 1'b0;
         in_chain_q <= 1'b0;
         rx_rise_q <= 1'b0;
         rx_fall_q <= 1'b0;
         pairs_q <= 8'h00;
      end else begin
         in_rise_q <= in_rise_d;
         in_fall_rt_q <= in_fall_rt_d;
         in_chain_q <= in_chain_d;
         rx_rise_q <= rx_rise_d;
         rx_fall_q <= rx_fall_d;
         pairs_q <= pairs_d;
      end
   end

   // output and enable registers, loaded from the core on link rise edges
   reg out_rise_q;
   reg out_fall_q;
   reg oe_q;
   reg out_rise_d;
   reg out_fall_d;
   reg oe_d;
   reg pad_out_d;

   always @* begin
      out_rise_d = out_rise_q;
      out_fall_d = out_fall_q;
      oe_d = oe_q;
      pad_out_d = pad_out;
      if (clr_pulse) begin
         out_rise_d = clr_val;
         out_fall_d = clr_val;
         oe_d = clr_val;
         pad_out_d = clr_val;
      end else if (lrise) begin
         out_rise_d = tx_rise_q;
         out_fall_d = tx_fall_q;
         oe_d = ctrl_q[`CTRL_OUT_EN];
         // rise value stands through the high half of the link clock
         pad_out_d = tx_rise_q;
      end else if (lfall && ddr_en) begin
         // second half period carries the fall value; sdr holds the rise value
         pad_out_d = out_fall_q;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_rise_q <= 1'b0;
         out_fall_q <= 1'b0;
         oe_q <= 1'b0;
         pad_out <= 1'b0;
      end else begin
         out_rise_q <= out_rise_d;
         out_fall_q <= out_fall_d;
         oe_q <= oe_d;
         pad_out <= pad_out_d;
      end
   end

   // rated up to `DDR_MAX_MHZ; at this sampling rate the link must be far slower
   assign pad_oe_n = ~oe_q;

   // two-bit pair words share one layout: fall in bit 1, rise in bit 0
   function [31:0] pair_word;
      input fall;
      input rise;
      begin
         pair_word = {30'h0000_0000, fall, rise};
      end
   endfunction

   // status word: pair count, synced link clock level, hot insertion state
   function [31:0] status_word;
      input [7:0] pairs;
      input lclk;
      input hot;
      begin
         status_word = {16'h0000, pairs, 6'b00_0000, lclk, hot};
      end
   endfunction

   // read data is taken in the setup phase so the access phase needs no wait
   reg [31:0] prdata_d;
   reg pslverr_d;

   // reads have no side effects; the words stand until the next setup cycle
   always @* begin
      prdata_d = prdata;
      pslverr_d = pslverr;
      if (setup) begin
         pslverr_d = ~mapped(paddr);
         case (paddr)
            `OFS_CTRL: prdata_d = ctrl_q;
            `OFS_STATUS: prdata_d = status_word(pairs_q, lclk_s, hot_insert_en);
            `OFS_TXDATA: prdata_d = pair_word(tx_fall_q, tx_rise_q);
            `OFS_RXDATA: prdata_d = pair_word(rx_fall_q, rx_rise_q);
            `OFS_PRESET: prdata_d = {31'h0000_0000, preset_val_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         prdata <= prdata_d;
         pslverr <= pslverr_d;
      end
   end

endmodule

// ==== test/io_cell_properties.sv ====
// port checker for the i/o register cell
`timescale 1ns/1ps
module io_cell_properties (
   // apb
   input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata,
   // link
   input wire link_clk, pad_in, pad_out, pad_oe_n, hot_insert_en
);
   reg [31:0] ctrl_q, tx_q;
   wire wr = psel && penable && pwrite;
   wire rd = psel && penable && !pwrite;
   // shadow copies built from bus traffic only
   always @(posedge pclk or negedge presetn)
      if (!presetn) begin
         ctrl_q <= 32'h0000_0040;
         tx_q <= 32'h0000_0000;
      end else if (wr) begin
         if (paddr == 12'h000) ctrl_q <= pwdata;
         if (paddr == 12'h008) tx_q <= pwdata;
      end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence link_up; $rose(link_clk); endsequence
   sequence ddr_down; $fell(link_clk) && ctrl_q[0]; endsequence
   a_ready_high: assert property (pready) else $error("pready low");
   a_bad_addr: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
      else $error("unmapped access without error");
   a_bad_read: assert property (rd && paddr > 12'h010 |-> prdata == 0)
      else $error("unmapped read not zero");
   a_ctrl_read: assert property (
      rd && paddr == 12'h000 |-> prdata == (ctrl_q & 32'h0000_03ff))
      else $error("ctrl readback wrong");
   a_hot_gate: assert property (
      hot_insert_en == (ctrl_q[3] && !ctrl_q[4] && !ctrl_q[5]))
      else $error("hot insertion wrong");
   a_rise_out: assert property (link_up |-> ##[2:4] pad_out == tx_q[0])
      else $error("rise value not driven");
   a_fall_out: assert property (ddr_down |-> ##[2:4] pad_out == tx_q[1])
      else $error("fall value not driven");
   a_oe_drive: assert property (link_up |-> ##[2:4] pad_oe_n == !ctrl_q[1])
      else $error("enable not taken");
   a_sdr_hold: assert property (
      $fell(link_clk) && !ctrl_q[0] |-> ##1 $stable(pad_out) [*4])
      else $error("sdr output moved");
endmodule
bind io_ddr_register_cell io_cell_properties u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .link_clk, .pad_in, .pad_out,
   .pad_oe_n, .hot_insert_en);

// ==== test/link_partner.sv ====
// far-side chip model driving link clock and data
`timescale 1ns/1ps
module link_partner (
   // link toward the cell
   output logic link_clk,
   output logic pad_in
);
   initial begin
      link_clk = 1'b0;
      pad_in = 1'b0;
   end
   // one period, data centred on each edge
   task send(input logic [1:0] p);
      pad_in = p[0];
      #200 link_clk = 1'b1;
      #200 pad_in = p[1];
      #200 link_clk = 1'b0;
      #200;
   endtask
   // clock stands still between frames; released data shows the inverse
   task frame(input logic [3:0] d);
      #37;
      send(d[1:0]);
      send(d[3:2]);
      pad_in = ~pad_in;
   endtask
endmodule

// ==== test/testbench.sv ====
// bench for the i/o register cell
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rdata;
   wire [31:0] prdata;
   wire pready, pslverr, link_clk, pad_in, pad_out, pad_oe_n, hot_insert_en;
   logic rerr;
   logic [3:0] d;
   int errors = 0, n_compared = 0;
   always #50 pclk = ~pclk;
   io_ddr_register_cell dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .link_clk, .pad_in, .pad_out, .pad_oe_n, .hot_insert_en);
   link_partner u_far (.link_clk, .pad_in);
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(n, e, rdata & m)
   endtask
   task give_verdict;
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #1_000_000;
      errors++;
      give_verdict;
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(12'h000, 32'hffff_ffff, 32'h0000_0040, "ctrl");
      rchk(12'h004, 32'h0000_ff01, 32'h0000_0000, "status");
      rchk(12'h014, 32'hffff_ffff, 32'h0000_0000, "unmapped");
      `CHK("slverr", 1'b1, rerr)
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'h000, 32'h0000_0048 | (i << 4));
         rchk(12'h004, 32'h0000_0001, i == 0, "hot_stat");
         `CHK("hot", i == 0, hot_insert_en)
      end
      // bypass, then tap code 0; each must land bit 1 of its frame as fall and bit 2 as rise
      for (int i = 0; i < 2; i++) begin
         d = i ? 4'b1001 : 4'b0110;
         apb(1'b1, 12'h000, i ? 32'h0000_0003 : 32'h0000_0043);
         apb(1'b1, 12'h008, 2 - i);
         u_far.frame(d);
         rchk(12'h00c, 32'h0000_0003, {d[1], d[2]}, "rx_pair");
         rchk(12'h004, 32'h0000_ff00, (i + 1) << 9, "pairs");
         `CHK("ddr_out", i == 0, pad_out)
         `CHK("oe_n", 1'b0, pad_oe_n)
      end
      apb(1'b1, 12'h000, 32'h0000_0042);
      u_far.frame(4'b0101);
      rchk(12'h00c, 32'h0000_0003, 32'h0000_0001, "rx_sdr");
      rchk(12'h004, 32'h0000_ff00, 32'h0000_0400, "pairs_sdr");
      `CHK("sdr_out", 1'b1, pad_out)
      for (int v = 0; v < 2; v++) begin
         apb(1'b1, 12'h010, 2 | v);
         rchk(12'h00c, 32'h0000_0003, v ? 32'h0000_0003 : 32'h0000_0000, "rx_preset");
         `CHK("pad_preset", v[0], pad_out)
         `CHK("oe_preset", ~v[0], pad_oe_n)
      end
      give_verdict;
   end
endmodule
